// *** shared/psp_consts.svh ***
// Purpose: Constants of the pipelined SRAM pin interface.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define PSP_ADDR_W 18
`define PSP_UPPER_W 16
`define PSP_BURST_W 2
`define PSP_LANES 4
`define PSP_BYTE_W 8
`define PSP_LANE_W 9
`define PSP_DATA_W 32
`define PSP_DEPTH 262144

// ----------------------------------------
// Burst order strap levels
// ----------------------------------------
`define PSP_ORDER_INTERLEAVED 1'b1
`define PSP_ORDER_LINEAR 1'b0

`endif

// *** shared/psp_pkg.sv ***
// Purpose: Types shared by the pipelined SRAM pin interface.
// Assumes: psp_consts.svh is on the include path.
// Notes:   Types only; numbers live in the header.
`include "psp_consts.svh"

package psp_pkg;

    // ----------------------------------------
    // One pipeline stage of an access
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [`PSP_ADDR_W-1:0] addr;
    } psp_cmd_t;

endpackage

// *** hw/psp_sram.sv ***
// Purpose: Pipelined burst static memory behind its synchronous pins.
// Assumes: The controller runs on sys_clk; all synchronous pins are already in this domain.
// Notes:   Read data follows one qualified edge after the command; write data two.
`timescale 1ns/1ns
`include "psp_consts.svh"

// Behaviour
// - capture full address at edge, select location
// - each lane select gates byte and parity
// - write enable sampled only when qualifier low
// - advance high steps burst counter
// - advance low loads fresh external address
// - clock edges count only with qualifier low
// - select needs first low, second high, third low
// - output enable low lets drivers turn on
// - output enable high keeps pins as inputs
// - drivers off during write data phase
// - drivers off first cycle after deselect
// - drivers off while deselected
// - qualifier high extends previous cycle, no deselect
// - output registered from preceding edge's location
// - strap high interleaved, low linear, fixed
module psp_sram (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Address and control
    input wire logic [`PSP_UPPER_W-1:0] addr_upper,
    input wire logic [`PSP_BURST_W-1:0] burst_addr_lsbs,
    input wire logic write_enable_n,
    input wire logic lane_a_write_sel_n,
    input wire logic lane_b_write_sel_n,
    input wire logic lane_c_write_sel_n,
    input wire logic lane_d_write_sel_n,
    input wire logic load_or_advance,
    input wire logic clock_qualifier_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic output_enable_n,
    input wire logic burst_order_strap,
    // Data pins, split into in, out and enable
    input wire logic [`PSP_DATA_W-1:0] data_in,
    input wire logic [`PSP_LANES-1:0] parity_lines_in,
    output logic [`PSP_DATA_W-1:0] data_out,
    output logic [`PSP_LANES-1:0] parity_lines_out,
    output logic data_oe
);

    // ----------------------------------------
    // Qualification and selection
    // ----------------------------------------
    logic qual;
    logic sel_now;
    logic [`PSP_LANES-1:0] lane_sel_n;
    psp_pkg::psp_cmd_t stage1_reg;
    psp_pkg::psp_cmd_t stage1_next;
    psp_pkg::psp_cmd_t stage2_reg;
    logic [`PSP_BURST_W-1:0] base_lsbs_reg;
    logic [`PSP_BURST_W-1:0] count_reg;
    logic [`PSP_BURST_W-1:0] count_next;
    logic mode_reg;
    logic drive_reg;
    logic [`PSP_LANES*`PSP_LANE_W-1:0] out_reg;
    logic [`PSP_LANES*`PSP_LANE_W-1:0] rd_word;

    assign qual = ~clock_qualifier_n;
    assign sel_now = ~chip_sel_first_n & chip_sel_second & ~chip_sel_third_n;
    assign lane_sel_n = {lane_d_write_sel_n, lane_c_write_sel_n, lane_b_write_sel_n, lane_a_write_sel_n};

    // ----------------------------------------
    // Burst order strap
    // ----------------------------------------
    // Caught while reset is held; the strap must not move afterwards
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode_reg <= burst_order_strap;
        end
    end

    // ----------------------------------------
    // Command capture and burst counter
    // ----------------------------------------
    assign count_next = count_reg + 2'h1;

    always_comb begin
        stage1_next = stage1_reg;
        if (load_or_advance) begin
            // Advance keeps the previous operation; a deselect stays deselected
            stage1_next.addr[`PSP_BURST_W-1:0] = (mode_reg == `PSP_ORDER_INTERLEAVED) ?
                (base_lsbs_reg ^ count_next) : (base_lsbs_reg + count_next);
        end else begin
            stage1_next.valid = sel_now;
            stage1_next.write = sel_now & ~write_enable_n;
            stage1_next.addr = {addr_upper, burst_addr_lsbs};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1_reg <= '0;
            base_lsbs_reg <= 2'h0;
            count_reg <= 2'h0;
        end else if (qual) begin
            stage1_reg <= stage1_next;
            if (load_or_advance) begin
                count_reg <= count_next;
            end else begin
                base_lsbs_reg <= burst_addr_lsbs;
                count_reg <= 2'h0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage2_reg <= '0;
        end else if (qual) begin
            stage2_reg <= stage1_reg;
        end
    end

    // ----------------------------------------
    // Storage, one array per byte lane
    // ----------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < `PSP_LANES; lane++) begin : g_lane
            logic [`PSP_LANE_W-1:0] lane_mem [`PSP_DEPTH];
            // Late write: data and selects arrive two edges after the command
            always_ff @(posedge sys_clk) begin
                if (qual && stage2_reg.valid && stage2_reg.write && !lane_sel_n[lane]) begin
                    lane_mem[stage2_reg.addr] <= {parity_lines_in[lane], data_in[lane*`PSP_BYTE_W +: `PSP_BYTE_W]};
                end
            end
            assign rd_word[lane*`PSP_LANE_W +: `PSP_LANE_W] = lane_mem[stage1_reg.addr];
            assign data_out[lane*`PSP_BYTE_W +: `PSP_BYTE_W] = out_reg[lane*`PSP_LANE_W +: `PSP_BYTE_W];
            assign parity_lines_out[lane] = out_reg[lane*`PSP_LANE_W + `PSP_BYTE_W];
        end
    endgenerate

    // ----------------------------------------
    // Output register and driver control
    // ----------------------------------------
    // No forwarding: a read right behind a write to the same word sees old data
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_reg <= '0;
        end else if (qual && stage1_reg.valid && !stage1_reg.write) begin
            out_reg <= rd_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            drive_reg <= 1'b0;
        end else if (qual) begin
            // Off for write data, deselect and the cycle emerging from deselect
            drive_reg <= stage1_reg.valid & ~stage1_reg.write & stage2_reg.valid;
        end
    end

    // Output enable acts without the clock, so it gates the registered enable directly
    assign data_oe = drive_reg & ~output_enable_n;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_load_address: assert property (@(posedge sys_clk) disable iff (reset)
        qual && !load_or_advance |=> stage1_reg.addr == {$past(addr_upper), $past(burst_addr_lsbs)})
        else $error("loaded address differs from pins");

    chk_write_qualified: assert property (@(posedge sys_clk) disable iff (reset)
        qual && !load_or_advance && sel_now |=> stage1_reg.write == !$past(write_enable_n))
        else $error("write flag not taken from write enable");

    chk_burst_step: assert property (@(posedge sys_clk) disable iff (reset)
        qual && load_or_advance |=> stage1_reg.addr[`PSP_ADDR_W-1:`PSP_BURST_W] ==
            $past(stage1_reg.addr[`PSP_ADDR_W-1:`PSP_BURST_W]) && count_reg == $past(count_reg) + 2'h1)
        else $error("burst advance wrong");

    chk_deselect_valid: assert property (@(posedge sys_clk) disable iff (reset)
        qual && !load_or_advance && !sel_now |=> !stage1_reg.valid)
        else $error("deselect did not clear access");

    chk_oe_allows: assert property (@(posedge sys_clk) disable iff (reset)
        $past(qual && stage1_reg.valid && !stage1_reg.write && stage2_reg.valid) && !output_enable_n |-> data_oe)
        else $error("drivers held off with output enable low");

    chk_oe_high_off: assert property (@(posedge sys_clk) disable iff (reset)
        output_enable_n |-> !data_oe)
        else $error("drivers on with output enable high");

    chk_write_no_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (qual && sel_now && !write_enable_n && !load_or_advance) ##1 qual |=> !data_oe)
        else $error("drivers on during write data");

    chk_emerge_no_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (qual && !sel_now && !load_or_advance) ##1 (qual && sel_now && !load_or_advance) |=> ##1 !drive_reg)
        else $error("drivers on first cycle after deselect");

    chk_desel_no_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (qual && !sel_now && !load_or_advance) ##1 qual |=> !data_oe)
        else $error("drivers on while deselected");

    chk_masked_hold: assert property (@(posedge sys_clk) disable iff (reset)
        !qual |=> $stable(out_reg) && $stable(drive_reg) && $stable(stage1_reg))
        else $error("state moved on a masked edge");

    chk_read_drive: assert property (@(posedge sys_clk) disable iff (reset)
        (qual && stage1_reg.valid && !stage1_reg.write && stage2_reg.valid) |=> drive_reg && out_reg == $past(rd_word))
        else $error("read data not registered");

    chk_strap_fixed: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> $stable(mode_reg))
        else $error("burst order changed in operation");

endmodule // psp_sram

// *** sim/psp_ctrl_model.sv ***
// Purpose: Controller model that drives the memory pins.
// Assumes: Pins change only at the falling clock edge.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ns
module psp_ctrl_model (
    // Clock
    input wire logic sys_clk
);
    logic [15:0] addr_upper;
    logic [1:0] burst_addr_lsbs;
    logic write_enable_n, load_or_advance, clock_qualifier_n, output_enable_n;
    logic chip_sel_first_n, chip_sel_second, chip_sel_third_n;
    logic [3:0] sel_n;
    logic [35:0] wdata;
    initial begin
        {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = 3'h6;
        {write_enable_n, load_or_advance, clock_qualifier_n, output_enable_n} = 4'h8;
        {addr_upper, burst_addr_lsbs} = 18'h0;
        sel_n = 4'hf;
        wdata = 36'h0;
    end
    task automatic op(input logic [2:0] ce, input logic we_n, ld, cq_n, input logic [17:0] a,
                      input logic wv, input logic [3:0] ln_n, input logic [35:0] wd);
        @(negedge sys_clk);
        {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = ce;
        write_enable_n = we_n;
        load_or_advance = ld;
        clock_qualifier_n = cq_n;
        {addr_upper, burst_addr_lsbs} = a;
        sel_n = wv ? ln_n : 4'hf;
        // A stale copy could hide a missed sample, so idle lines flip
        wdata = wv ? wd : ~wdata;
    endtask
endmodule // psp_ctrl_model

// *** sim/tb_pipelined_sram_pin_interface.sv ***
// Purpose: Self-checking bench of the memory pin interface.
// Assumes: Outputs are looked at on the falling edge.
// Notes: Memory is never cleared, so A is written fully first.
`timescale 1ns/1ns
module tb_pipelined_sram_pin_interface;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] DES = 3'h6;
    localparam logic [17:0] A = 18'h21234;
    localparam logic [35:0] W0 = 36'hf_ffff_ffff;
    localparam logic [35:0] W1 = 36'h0;
    localparam logic [35:0] M = 36'ha_ff00_ff00;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic strap = 1'h1;
    int num_errors = 0;
    int checks_done = 0;
    always #2 sys_clk = ~sys_clk;
    psp_ctrl_model c (.sys_clk(sys_clk));
    psp_sram uut (.sys_clk(sys_clk), .reset(reset), .addr_upper(c.addr_upper),
        .burst_addr_lsbs(c.burst_addr_lsbs), .write_enable_n(c.write_enable_n),
        .lane_a_write_sel_n(c.sel_n[0]), .lane_b_write_sel_n(c.sel_n[1]),
        .lane_c_write_sel_n(c.sel_n[2]), .lane_d_write_sel_n(c.sel_n[3]),
        .load_or_advance(c.load_or_advance), .clock_qualifier_n(c.clock_qualifier_n),
        .chip_sel_first_n(c.chip_sel_first_n), .chip_sel_second(c.chip_sel_second),
        .chip_sel_third_n(c.chip_sel_third_n), .output_enable_n(c.output_enable_n),
        .burst_order_strap(strap), .data_in(c.wdata[31:0]), .parity_lines_in(c.wdata[35:32]),
        .data_out(), .parity_lines_out(), .data_oe());
    task ck(input string nm, input logic [35:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task see(input logic [35:0] exp, input logic oe);
        ck("rdata", {uut.parity_lines_out, uut.data_out}, exp);
        ck("oe", {35'h0, uut.data_oe}, {35'h0, oe});
    endtask
    task rd(input logic [17:0] a);
        c.op(SEL, 1'h1, 1'h0, 1'h0, a, 1'h0, 4'hf, 36'h0);
    endtask
    task wr(input logic [17:0] a, input logic wv, input logic [35:0] wd);
        c.op(SEL, 1'h0, 1'h0, 1'h0, a, wv, 4'h0, wd);
    endtask
    task nop(input logic wv, input logic [3:0] ln, input logic [35:0] wd);
        c.op(DES, 1'h1, 1'h0, 1'h0, 18'h0, wv, ln, wd);
    endtask
    function logic [35:0] word(input int n);
        return 36'(n + 1) * 36'h1_1111_1111;
    endfunction
    task do_reset(input logic s);
        strap = s;
        reset = 1'h1;
        repeat (10) @(negedge sys_clk);
        reset = 1'h0;
    endtask
    task t_write_read;
        wr(A, 1'h0, 36'h0);
        wr(A, 1'h0, 36'h0);
        nop(1'h1, 4'h0, W0);
        nop(1'h1, 4'ha, W1);
        rd(A);
        rd(A);
        nop(1'h0, 4'hf, 36'h0);
        see(M, 1'h0);
        nop(1'h0, 4'hf, 36'h0);
        see(M, 1'h1);
        c.output_enable_n = 1'h1;
        #1 ck("oe", {35'h0, uut.data_oe}, 36'h0);
        @(negedge sys_clk) c.output_enable_n = 1'h0;
        nop(1'h0, 4'hf, 36'h0);
        see(M, 1'h0);
    endtask
    task t_mask;
        rd(A);
        rd(A);
        // Masked write to A; its data follows, so a taken edge would clear A
        c.op(SEL, 1'h0, 1'h0, 1'h1, A, 1'h0, 4'hf, 36'h0);
        c.op(SEL, 1'h0, 1'h0, 1'h1, A, 1'h1, 4'h0, W1);
        see(M, 1'h0);
        wr(18'h40, 1'h1, W1);
        nop(1'h0, 4'hf, 36'h0);
        see(M, 1'h1);
        nop(1'h1, 4'h0, W1);
        see(M, 1'h0);
        rd(A);
        nop(1'h0, 4'hf, 36'h0);
        nop(1'h0, 4'hf, 36'h0);
        see(M, 1'h0);
    endtask
    task t_sel;
        for (int i = 0; i < 8; i++) begin
            if (i != 2) begin
                c.op(3'(i), 1'h0, 1'h0, 1'h0, A, 1'h0, 4'hf, 36'h0);
                nop(1'h0, 4'hf, 36'h0);
                nop(1'h1, 4'h0, W1);
                ck("oe", {35'h0, uut.data_oe}, 36'h0);
            end
        end
        rd(A);
        nop(1'h0, 4'hf, 36'h0);
        nop(1'h0, 4'hf, 36'h0);
        see(M, 1'h0);
    endtask
    task t_fill;
        for (int i = 0; i < 6; i++) begin
            c.op(i < 4 ? SEL : DES, 1'h0, 1'h0, 1'h0, 18'(i), i >= 2, 4'h0, word(i - 2));
        end
    endtask
    task t_burst(input logic [7:0] ord);
        for (int k = 0; k < 6; k++) begin
            c.op(k < 4 ? SEL : DES, 1'h1, k > 0 && k < 4, 1'h0, 18'h1, 1'h0, 4'hf, 36'h0);
            if (k >= 2) begin
                ck("burst", {uut.parity_lines_out, uut.data_out}, word(int'(ord[2*(k-2)+:2])));
            end
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Traffic is near 80 cycles with resets; 5000 cycles is ample
    initial begin
        #20000;
        num_errors++;
        stop_test();
    end
    initial begin
        do_reset(1'h1);
        t_write_read();
        t_mask();
        t_sel();
        t_fill();
        t_burst(8'hb1);
        do_reset(1'h0);
        t_burst(8'h39);
        stop_test();
    end
endmodule // tb_pipelined_sram_pin_interface
